// ===== common/cmdf_map.svh
// Functional notes
// - direction bit 1 moves into the register field operand, 0 from it.
// - width bit 1 selects a 16-bit word operation, 0 an 8-bit byte.
// - sign-extension bit 0 takes a full 16-bit immediate from the stream.
// - sign-extension bit 1 takes one immediate byte and sign-extends it.
// - of two clock counts, the smaller is for register, larger for memory.
// - one extra clock when the address calculation sums three elements.
// - protected-only instruction in real mode raises undefined opcode, 6.
// - real mode word access at offset FFFF raises segment overrun, 13.
// - real mode keeps privilege field and nested-task flag at zero.
// - real mode coprocessor operand past segment limit raises vector 9.
// - marked instructions assert bus lock automatically, prefix or not.
// - protected limit or access breach raises 13; stack limit raises 12.
// - protected segment load checks privilege; absent gives 11, stack 12.
// - descriptor table accesses of such instructions assert bus lock.
// - protected I/O-sensitive op faults 13 if privilege above field.
// - loaded flags keep interrupt enable if privilege > field; field at 0.
// - selector privilege failure: no fault, no result, zero flag cleared.
// - escape raises 13 or 12 before execution, 9 on transfer overrun.
// - transfer target outside code segment limit raises 13.
// - transfer to another code segment breaking privilege raises 13.
// - 1010000w, address low then high, loads accumulator, 5 clocks.
`ifndef CMDF_MAP_SVH
`define CMDF_MAP_SVH

// opcode patterns
`define CMDF_OP_MOVRM   6'h22
`define CMDF_OP_IMMRM   7'h63
`define CMDF_OP_IMMR    4'hB
`define CMDF_OP_MTOA    7'h50
`define CMDF_OP_ATOM    7'h51
`define CMDF_OP_RMTOS   8'h8E
`define CMDF_OP_STORM   8'h8C
`define CMDF_OP_PUSHI   7'h34

// register field codes
`define CMDF_REG_SS     3'h2
`define CMDF_REG_ACC    3'h0

// exception vectors
`define CMDF_VEC_UD     8'h06
`define CMDF_VEC_COP    8'h09
`define CMDF_VEC_NP     8'h0B
`define CMDF_VEC_SS     8'h0C
`define CMDF_VEC_GP     8'h0D

// offset that makes a word access overrun
`define CMDF_OFS_LAST   16'hFFFF

// clock counts
`define CMDF_CLK_REG    5'h02
`define CMDF_CLK_MWR    5'h03
`define CMDF_CLK_MRD    5'h05
`define CMDF_CLK_MTOA   5'h05
`define CMDF_CLK_ATOM   5'h03
`define CMDF_CLK_PUSHI  5'h03
`define CMDF_CLK_SEGPR  5'h11
`define CMDF_CLK_SEGPM  5'h13
`define CMDF_CLK_EA3    5'h01

// flag word layout and reset
`define CMDF_FLG_IF     9
`define CMDF_FLG_IO_PRIVILEGE_FIELD   12
`define CMDF_FLG_NT     14
`define CMDF_FLG_RST    16'h0000

`endif

// ===== common/cmdf_pkg.sv
package cmdf_pkg;

   typedef enum logic [2:0] {
      S_OPC = 3'b000,
      S_MRM = 3'b001,
      S_DSP = 3'b010,
      S_IMM = 3'b011,
      S_CHK = 3'b100
   } cmdf_state_t;

   typedef enum logic [3:0] {
      K_NONE  = 4'b0000,
      K_RTORM = 4'b0001,
      K_RMTOR = 4'b0010,
      K_IMMRM = 4'b0011,
      K_IMMR  = 4'b0100,
      K_MTOA  = 4'b0101,
      K_ATOM  = 4'b0110,
      K_RMTOS = 4'b0111,
      K_STORM = 4'b1000,
      K_PUSHI = 4'b1001
   } cmdf_kind_t;

   typedef logic [7:0] cmdf_vec_t;

   typedef struct packed {
      cmdf_state_t state;
      cmdf_kind_t  kind;
      logic [7:0]  opc;
      logic [7:0]  mrm;
      logic [7:0]  dlo;
      logic [7:0]  dhi;
      logic [7:0]  ilo;
      logic [7:0]  ihi;
      logic [1:0]  dlen;
      logic [1:0]  ilen;
      logic        cnt;
      logic        opV;
      logic        dirToReg;
      logic        wide;
      logic [2:0]  regField;
      logic [15:0] operand;
      logic [15:0] address;
      logic [4:0]  clocks;
      logic        fV;
      cmdf_vec_t   vector;
      logic        zClr;
      logic        lock;
      logic [15:0] flags;
   } cmdf_st_t;

endpackage

// ===== core/cmdf_imm_form.sv
`timescale 1ns/10ps
module cmdf_imm_form (
   // bytes in stream order
   input  wire logic [7:0]  lo,
   input  wire logic [7:0]  hi,
   // form selection
   input  wire logic        wide,
   input  wire logic        sext,
   // 16-bit result
   output logic      [15:0] value
);
   always_comb begin
      if (sext) begin
         value = {{8{lo[7]}}, lo};
      end else if (wide) begin
         value = {hi, lo};
      end else begin
         value = {8'h00, lo};
      end
   end
endmodule

// ===== core/cmdf_decoder.sv
`timescale 1ns/10ps
`include "cmdf_map.svh"
module cmdf_decoder (
   // clock and reset
   input  wire logic                clock,
   input  wire logic                rst,
   // instruction byte stream
   input  wire logic                byteValid,
   input  wire logic [7:0]          byteData,
   output logic                     byteReady,
   // operating state
   input  wire logic                protMode,
   input  wire logic [1:0]          currentPrivilegeLevel,
   // check request and answer
   output logic                     checkReq,
   input  wire logic                chkValid,
   input  wire logic [15:0]         eaOffset,
   input  wire logic                attrProtOnly,
   input  wire logic                attrIoSens,
   input  wire logic                attrEsc,
   input  wire logic                attrSelCheck,
   input  wire logic                attrSegLoad,
   input  wire logic                attrSsDest,
   input  wire logic                attrXfer,
   input  wire logic                attrFarXfer,
   input  wire logic                limitFail,
   input  wire logic                accessFail,
   input  wire logic                stackLimitFail,
   input  wire logic                segPrivFail,
   input  wire logic                segPresent,
   input  wire logic                targetOutOfLimit,
   input  wire logic                copOverrun,
   // bus lock
   input  wire logic                attrAutoLock,
   input  wire logic                descAccess,
   output logic                     lockOut,
   // flag word load
   input  wire logic                flagLoadValid,
   input  wire logic [15:0]         flagLoadData,
   output logic      [15:0]         flagWord,
   // decoded operation
   output logic                     opValid,
   output cmdf_pkg::cmdf_kind_t     opKind,
   output logic                     opDirToReg,
   output logic                     opWord,
   output logic      [2:0]          opRegField,
   output logic      [7:0]          opModrm,
   output logic      [15:0]         opOperand,
   output logic      [15:0]         opAddress,
   output logic      [4:0]          opClocks,
   // fault and selector results
   output logic                     faultValid,
   output cmdf_pkg::cmdf_vec_t      faultVector,
   output logic                     zeroResultFlagClear
);
   import cmdf_pkg::*;

   cmdf_st_t s_q;
   cmdf_st_t s_d;
   logic [15:0] immValue;
   logic [15:0] dispValue;
   logic        immWide;
   logic        immSext;
   logic        memOp;
   logic        isDirect;
   logic        threeEa;
   logic        segLoad;
   logic        ssDest;
   logic [1:0]  ioPrivilegeField;
   logic [15:0] chkOffset;
   logic        faultHit;
   cmdf_vec_t   faultVec;
   logic [15:0] nextFlags;

   function automatic cmdf_kind_t kindOf(input logic [7:0] o);
      if (o[7:2] == `CMDF_OP_MOVRM) begin
         kindOf = o[1] ? K_RMTOR : K_RTORM;
      end else if (o[7:1] == `CMDF_OP_IMMRM) begin
         kindOf = K_IMMRM;
      end else if (o[7:4] == `CMDF_OP_IMMR) begin
         kindOf = K_IMMR;
      end else if (o[7:1] == `CMDF_OP_MTOA) begin
         kindOf = K_MTOA;
      end else if (o[7:1] == `CMDF_OP_ATOM) begin
         kindOf = K_ATOM;
      end else if (o == `CMDF_OP_RMTOS) begin
         kindOf = K_RMTOS;
      end else if (o == `CMDF_OP_STORM) begin
         kindOf = K_STORM;
      end else if ({o[7:2], o[0]} == `CMDF_OP_PUSHI) begin
         kindOf = K_PUSHI;
      end else begin
         kindOf = K_NONE;
      end
   endfunction
   function automatic logic hasModrm(input cmdf_kind_t k);
      hasModrm = (k == K_RTORM) || (k == K_RMTOR) || (k == K_IMMRM) ||
                 (k == K_RMTOS) || (k == K_STORM);
   endfunction
   function automatic logic [1:0] immLen(input cmdf_kind_t k,
                                         input logic [7:0] o);
      case (k)
         K_IMMRM: immLen = o[0] ? 2'h2 : 2'h1;
         K_IMMR:  immLen = o[3] ? 2'h2 : 2'h1;
         K_PUSHI: immLen = o[1] ? 2'h1 : 2'h2;
         default: immLen = 2'h0;
      endcase
   endfunction
   function automatic logic [1:0] dispLen(input logic [7:0] m);
      case (m[7:6])
         2'h0:    dispLen = (m[2:0] == 3'h6) ? 2'h2 : 2'h0;
         2'h1:    dispLen = 2'h1;
         2'h2:    dispLen = 2'h2;
         default: dispLen = 2'h0;
      endcase
   endfunction
   function automatic logic [4:0] clockCount(input cmdf_kind_t k,
                                             input logic mem,
                                             input logic three,
                                             input logic prot);
      logic [4:0] base;
      base = 5'h00;
      case (k)
         K_RTORM, K_IMMRM, K_STORM:
            base = mem ? `CMDF_CLK_MWR : `CMDF_CLK_REG;
         K_RMTOR: base = mem ? `CMDF_CLK_MRD : `CMDF_CLK_REG;
         K_IMMR:  base = `CMDF_CLK_REG;
         K_MTOA:  base = `CMDF_CLK_MTOA;
         K_ATOM:  base = `CMDF_CLK_ATOM;
         K_PUSHI: base = `CMDF_CLK_PUSHI;
         K_RMTOS: begin
            if (prot) begin
               base = mem ? `CMDF_CLK_SEGPM : `CMDF_CLK_SEGPR;
            end else begin
               base = mem ? `CMDF_CLK_MRD : `CMDF_CLK_REG;
            end
         end
         default: base = 5'h00;
      endcase
      if (mem && three && hasModrm(k)) begin
         base = base + `CMDF_CLK_EA3;
      end
      clockCount = base;
   endfunction

   // immediate and displacement forming
   assign immWide = (s_q.kind == K_IMMR) ? s_q.opc[3] :
                    (s_q.kind >= K_RMTOS) ? 1'b1 : s_q.opc[0];
   assign immSext = (s_q.kind == K_PUSHI) && s_q.opc[1];
   cmdf_imm_form u_imm (
      .lo    (s_q.ilo),
      .hi    (s_q.ihi),
      .wide  (immWide),
      .sext  (immSext),
      .value (immValue)
   );
   cmdf_imm_form u_disp (
      .lo    (s_q.dlo),
      .hi    (s_q.dhi),
      .wide  (s_q.dlen == 2'h2),
      .sext  (s_q.dlen == 2'h1),
      .value (dispValue)
   );

   assign isDirect = (s_q.kind == K_MTOA) || (s_q.kind == K_ATOM) ||
                     (hasModrm(s_q.kind) && s_q.mrm[7:6] == 2'h0 &&
                      s_q.mrm[2:0] == 3'h6);
   assign memOp    = (s_q.kind == K_MTOA) || (s_q.kind == K_ATOM) ||
                     (hasModrm(s_q.kind) && s_q.mrm[7:6] != 2'h3);
   assign threeEa  = ^s_q.mrm[7:6] && !s_q.mrm[2];
   assign segLoad  = (s_q.kind == K_RMTOS) || attrSegLoad;
   assign ssDest   = (s_q.kind == K_RMTOS) ?
                     (s_q.mrm[5:3] == `CMDF_REG_SS) : attrSsDest;
   assign chkOffset = isDirect ? dispValue : eaOffset;
   assign ioPrivilegeField = s_q.flags[`CMDF_FLG_IO_PRIVILEGE_FIELD +: 2];

   // fault selection, highest priority first
   always_comb begin
      faultHit = 1'b1;
      faultVec = `CMDF_VEC_GP;
      if (!protMode) begin
         if (attrProtOnly) begin
            faultVec = `CMDF_VEC_UD;
         end else if (memOp && immWide && chkOffset == `CMDF_OFS_LAST) begin
            faultVec = `CMDF_VEC_GP;
         end else if (copOverrun) begin
            faultVec = `CMDF_VEC_COP;
         end else begin
            faultHit = 1'b0;
         end
      end else begin
         if (attrIoSens &&
             currentPrivilegeLevel > ioPrivilegeField) begin
            faultVec = `CMDF_VEC_GP;
         end else if ((memOp || attrEsc) && stackLimitFail) begin
            faultVec = `CMDF_VEC_SS;
         end else if ((memOp || attrEsc) && (limitFail || accessFail)) begin
            faultVec = `CMDF_VEC_GP;
         end else if (segLoad && segPrivFail && !attrSelCheck) begin
            faultVec = `CMDF_VEC_GP;
         end else if (segLoad && !segPresent) begin
            faultVec = ssDest ? `CMDF_VEC_SS : `CMDF_VEC_NP;
         end else if (attrXfer && targetOutOfLimit) begin
            faultVec = `CMDF_VEC_GP;
         end else if (attrXfer && attrFarXfer && segPrivFail) begin
            faultVec = `CMDF_VEC_GP;
         end else if (copOverrun) begin
            faultVec = `CMDF_VEC_COP;
         end else begin
            faultHit = 1'b0;
         end
      end
   end

   // flag word load
   always_comb begin
      nextFlags = flagLoadData;
      if (!protMode) begin
         nextFlags[`CMDF_FLG_IO_PRIVILEGE_FIELD +: 2] = 2'h0;
         nextFlags[`CMDF_FLG_NT]        = 1'b0;
      end else begin
         if (currentPrivilegeLevel > ioPrivilegeField) begin
            nextFlags[`CMDF_FLG_IF] = s_q.flags[`CMDF_FLG_IF];
         end
         if (currentPrivilegeLevel != 2'h0) begin
            nextFlags[`CMDF_FLG_IO_PRIVILEGE_FIELD +: 2] = ioPrivilegeField;
         end
      end
   end

   always_comb begin
      s_d      = s_q;
      s_d.opV  = 1'b0;
      s_d.fV   = 1'b0;
      s_d.zClr = 1'b0;
      // lock follows the marked instruction while it is in flight
      s_d.lock = ((s_q.state != S_OPC) && attrAutoLock) ||
                 (protMode && descAccess && segLoad);
      if (flagLoadValid) begin
         s_d.flags = nextFlags;
      end else if (!protMode) begin
         s_d.flags[`CMDF_FLG_IO_PRIVILEGE_FIELD +: 2] = 2'h0;
         s_d.flags[`CMDF_FLG_NT]        = 1'b0;
      end
      case (s_q.state)
         S_OPC: begin
            if (byteValid) begin
               s_d.opc  = byteData;
               s_d.kind = kindOf(byteData);
               s_d.mrm  = 8'h00;
               s_d.cnt  = 1'b0;
               s_d.dlen = 2'h0;
               s_d.ilen = immLen(kindOf(byteData), byteData);
               if (hasModrm(kindOf(byteData))) begin
                  s_d.state = S_MRM;
               end else if (kindOf(byteData) == K_MTOA ||
                            kindOf(byteData) == K_ATOM) begin
                  s_d.dlen  = 2'h2;
                  s_d.state = S_DSP;
               end else if (immLen(kindOf(byteData), byteData) != 2'h0) begin
                  s_d.state = S_IMM;
               end else begin
                  s_d.state = S_CHK;
               end
            end
         end
         S_MRM: begin
            if (byteValid) begin
               s_d.mrm  = byteData;
               s_d.dlen = dispLen(byteData);
               if (dispLen(byteData) != 2'h0) begin
                  s_d.state = S_DSP;
               end else if (s_q.ilen != 2'h0) begin
                  s_d.state = S_IMM;
               end else begin
                  s_d.state = S_CHK;
               end
            end
         end
         S_DSP: begin
            if (byteValid) begin
               // low byte first, then high byte
               if (!s_q.cnt) begin
                  s_d.dlo = byteData;
               end else begin
                  s_d.dhi = byteData;
               end
               s_d.cnt = !s_q.cnt;
               if ({1'b0, s_q.cnt} == s_q.dlen - 2'h1) begin
                  s_d.cnt   = 1'b0;
                  s_d.state = (s_q.ilen != 2'h0) ? S_IMM : S_CHK;
               end
            end
         end
         S_IMM: begin
            if (byteValid) begin
               if (!s_q.cnt) begin
                  s_d.ilo = byteData;
               end else begin
                  s_d.ihi = byteData;
               end
               s_d.cnt = !s_q.cnt;
               if ({1'b0, s_q.cnt} == s_q.ilen - 2'h1) begin
                  s_d.cnt   = 1'b0;
                  s_d.state = S_CHK;
               end
            end
         end
         S_CHK: begin
            if (chkValid) begin
               s_d.state = S_OPC;
               if (faultHit) begin
                  s_d.fV     = 1'b1;
                  s_d.vector = faultVec;
               end else if (attrSelCheck && segPrivFail) begin
                  s_d.zClr = 1'b1;
               end else begin
                  s_d.opV      = 1'b1;
                  s_d.wide     = immWide;
                  s_d.operand  = immValue;
                  s_d.address  = isDirect ? dispValue : eaOffset;
                  s_d.clocks = clockCount(s_q.kind, memOp, threeEa, protMode);
                  case (s_q.kind)
                     K_RTORM, K_RMTOR: s_d.dirToReg = s_q.opc[1];
                     K_MTOA, K_IMMR, K_RMTOS: s_d.dirToReg = 1'b1;
                     default: s_d.dirToReg = 1'b0;
                  endcase
                  if (s_q.kind == K_IMMR) begin
                     s_d.regField = s_q.opc[2:0];
                  end else if (s_q.kind == K_MTOA || s_q.kind == K_ATOM) begin
                     s_d.regField = `CMDF_REG_ACC;
                  end else begin
                     s_d.regField = s_q.mrm[5:3];
                  end
               end
            end
         end
         default: s_d.state = S_OPC;
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         s_q       <= '0;
         s_q.flags <= `CMDF_FLG_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign byteReady           = (s_q.state != S_CHK);
   assign checkReq            = (s_q.state == S_CHK);
   assign lockOut             = s_q.lock;
   assign flagWord            = s_q.flags;
   assign opValid             = s_q.opV;
   assign opKind              = s_q.kind;
   assign opDirToReg          = s_q.dirToReg;
   assign opWord              = s_q.wide;
   assign opRegField          = s_q.regField;
   assign opModrm             = s_q.mrm;
   assign opOperand           = s_q.operand;
   assign opAddress           = s_q.address;
   assign opClocks            = s_q.clocks;
   assign faultValid          = s_q.fV;
   assign faultVector         = s_q.vector;
   assign zeroResultFlagClear = s_q.zClr;

endmodule

// ===== testbench/cmdf_decoder_sva.sv
`timescale 1ns/10ps
module cmdf_decoder_sva (
   // clock and reset
   input wire logic                 clock,
   input wire logic                 rst,
   // check handshake and attributes
   input wire logic                 checkReq,
   input wire logic                 chkValid,
   input wire logic                 protMode,
   input wire logic [1:0]           currentPrivilegeLevel,
   input wire logic                 attrProtOnly,
   input wire logic                 attrIoSens,
   input wire logic                 attrAutoLock,
   input wire logic                 lockOut,
   // flag word
   input wire logic                 flagLoadValid,
   input wire logic [15:0]          flagWord,
   // results
   input wire logic                 opValid,
   input wire cmdf_pkg::cmdf_kind_t opKind,
   input wire logic                 opDirToReg,
   input wire logic [4:0]           opClocks,
   input wire logic                 faultValid,
   input wire cmdf_pkg::cmdf_vec_t  faultVector,
   input wire logic                 zeroResultFlagClear
);
   import cmdf_pkg::*;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   a_one_answer: assert property (
      checkReq && chkValid
      |=> $onehot({opValid, faultValid, zeroResultFlagClear}))
      else $error("check gave not exactly one answer");
   a_real_undef: assert property (
      checkReq && chkValid && !protMode && attrProtOnly
      |=> faultValid && faultVector == 8'h06) else $error("no vector 6");
   a_real_flags: assert property (
      flagLoadValid && !protMode |=> flagWord[14:12] == 3'h0)
      else $error("real mode flag fields not zero");
   a_io_priv: assert property (
      checkReq && chkValid && protMode && attrIoSens
      && currentPrivilegeLevel > flagWord[13:12]
      |=> faultValid && faultVector == 8'h0D) else $error("no io fault");
   a_if_keep: assert property (
      flagLoadValid && protMode && currentPrivilegeLevel > flagWord[13:12]
      |=> $stable(flagWord[9])) else $error("interrupt enable changed");
   a_io_privilege_field_keep: assert property (
      flagLoadValid && protMode && currentPrivilegeLevel != 2'h0
      |=> $stable(flagWord[13:12])) else $error("privilege field changed");
   a_auto_lock: assert property (
      checkReq && attrAutoLock |=> lockOut) else $error("lock not asserted");
   a_mtoa_form: assert property (
      opValid && opKind == K_MTOA |-> opDirToReg && opClocks == 5'h05)
      else $error("accumulator load misdecoded");
   c_push: cover property (opValid && opKind == K_PUSHI);
   c_selfail: cover property (zeroResultFlagClear);
   c_stack: cover property (faultValid && faultVector == 8'h0C);
endmodule

bind cmdf_decoder cmdf_decoder_sva u_sva (
   .clock, .rst, .checkReq, .chkValid, .protMode, .currentPrivilegeLevel,
   .attrProtOnly, .attrIoSens, .attrAutoLock, .lockOut, .flagLoadValid,
   .flagWord, .opValid, .opKind, .opDirToReg, .opClocks, .faultValid,
   .faultVector, .zeroResultFlagClear
);

// ===== testbench/cmdf_check_model.sv
`timescale 1ns/10ps
module cmdf_check_model (
   // clock and reset
   input  wire logic clock,
   input  wire logic rst,
   // check handshake
   input  wire logic checkReq,
   input  wire logic slow,
   output logic      chkValid
);
   logic [1:0] waitCnt_q;
   // answer at once, or three cycles late when slow
   always @(negedge clock) begin
      if (rst || !checkReq) begin
         chkValid <= 1'b0;
         waitCnt_q <= 2'h0;
      end else if (!slow || waitCnt_q == 2'h3) begin
         chkValid <= 1'b1;
      end else begin
         waitCnt_q <= waitCnt_q + 2'h1;
      end
   end
endmodule

// ===== testbench/cmdf_decoder_tb.sv
`timescale 1ns/10ps
module cmdf_decoder_tb;
   import cmdf_pkg::*;
   // stimulus
   logic        clock, rst, byteValid, protMode, attrAutoLock, descAccess;
   logic        flagLoadValid, slow;
   logic [7:0]  byteData;
   logic [1:0]  currentPrivilegeLevel;
   logic [14:0] at;
   logic [15:0] eaOffset, flagLoadData;
   // observed
   logic        byteReady, checkReq, chkValid, lockOut, opValid, opDirToReg;
   logic        opWord, faultValid, zeroResultFlagClear, lockSeen;
   logic [2:0]  opRegField;
   logic [7:0]  opModrm;
   logic [15:0] flagWord, opOperand, opAddress;
   logic [4:0]  opClocks;
   cmdf_kind_t  opKind;
   cmdf_vec_t   faultVector;
   int          miscompares, checked, ans;
   cmdf_decoder DUT (
      .clock, .rst, .byteValid, .byteData, .byteReady, .protMode,
      .currentPrivilegeLevel, .checkReq, .chkValid, .eaOffset,
      .attrProtOnly(at[14]), .attrIoSens(at[13]), .attrEsc(at[12]),
      .attrSelCheck(at[11]), .attrSegLoad(at[10]), .attrSsDest(at[9]),
      .attrXfer(at[8]), .attrFarXfer(at[7]), .limitFail(at[6]),
      .accessFail(at[5]), .stackLimitFail(at[4]), .segPrivFail(at[3]),
      .segPresent(~at[2]), .targetOutOfLimit(at[1]), .copOverrun(at[0]),
      .attrAutoLock, .descAccess, .lockOut, .flagLoadValid, .flagLoadData,
      .flagWord, .opValid, .opKind, .opDirToReg, .opWord, .opRegField,
      .opModrm, .opOperand, .opAddress, .opClocks, .faultValid,
      .faultVector, .zeroResultFlagClear
   );
   cmdf_check_model partner (.clock, .rst, .checkReq, .slow, .chkValid);
   task automatic give_verdict();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic stuck();
      miscompares++;
      give_verdict();
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // one instruction, then its answer
   task automatic issue(input logic [7:0] b [$]);
      int n;
      ans = -1;
      lockSeen = 1'b0;
      foreach (b[i]) begin
         @(negedge clock);
         byteValid = 1'b1;
         byteData = b[i];
         for (n = 0; !byteReady && n < 20; n++) @(negedge clock);
         if (n == 20) stuck();
      end
      @(negedge clock);
      byteValid = 1'b0;
      for (n = 0; ans < 0 && n < 20; n++) begin
         @(posedge clock);
         #1;
         lockSeen |= lockOut;
         if (opValid === 1'b1) ans = 0;
         else if (faultValid === 1'b1) ans = 1;
         else if (zeroResultFlagClear === 1'b1) ans = 2;
      end
      if (ans < 0) stuck();
   endtask
   // c[5] gates the direction, width and register compare
   task automatic mv(input logic [7:0] b [$], input cmdf_kind_t k,
                     input logic [5:0] c, input logic [4:0] t,
                     input logic [15:0] v);
      issue(b);
      chk(16'(ans), 16'h0000);
      chk(16'(opKind), 16'(k));
      chk(16'(opClocks), 16'(t));
      if (c[5]) chk(16'({opDirToReg, opWord, opRegField}), 16'(c[4:0]));
      if (k != K_RTORM && k != K_RMTOR)
         chk(k == K_MTOA ? opAddress : opOperand, v);
   endtask
   task automatic fl(input logic [7:0] b [$], input logic [14:0] m,
                     input int a, input cmdf_vec_t v);
      @(negedge clock);
      at = m;
      issue(b);
      chk(16'(ans), 16'(a));
      if (a == 1) chk(16'(faultVector), 16'(v));
      @(negedge clock);
      at = 15'h0000;
   endtask
   task automatic t_moves();
      mv('{8'hA1, 8'h34, 8'h12}, K_MTOA, 6'h38, 5'h05, 16'h1234);
      mv('{8'hA0, 8'h78, 8'h56}, K_MTOA, 6'h30, 5'h05, 16'h5678);
      mv('{8'h88, 8'hD8}, K_RTORM, 6'h23, 5'h02, 16'h0000);
      mv('{8'h8B, 8'h07}, K_RMTOR, 6'h38, 5'h05, 16'h0000);
      mv('{8'h8B, 8'h40, 8'h05}, K_RMTOR, 6'h38, 5'h06, 16'h0000);
      mv('{8'h6A, 8'h80}, K_PUSHI, 6'h00, 5'h03, 16'hFF80);
      mv('{8'h68, 8'h34, 8'h12}, K_PUSHI, 6'h00, 5'h03, 16'h1234);
      mv('{8'hB8, 8'hCD, 8'hAB}, K_IMMR, 6'h00, 5'h02, 16'hABCD);
      $display("moves test done");
   endtask
   task automatic t_flags();
      logic [1:0]  pl [5] = '{2'h0, 2'h0, 2'h2, 2'h0, 2'h1};
      logic [15:0] dt [5] = '{16'h7200, 16'h3200, 16'h0000, 16'h0000,
                              16'h0200};
      logic [3:0]  ex [5] = '{4'h1, 4'h7, 4'h6, 4'h0, 4'h0};
      for (int i = 0; i < 5; i++) begin
         @(negedge clock);
         protMode = i > 0;
         currentPrivilegeLevel = pl[i];
         flagLoadValid = 1'b1;
         flagLoadData = dt[i];
         @(negedge clock);
         flagLoadValid = 1'b0;
         chk(16'({flagWord[14:12], flagWord[9]}), 16'(ex[i]));
      end
      $display("flags test done");
   endtask
   task automatic t_real_faults();
      protMode = 1'b0;
      fl('{8'h90}, 15'h4000, 1, 8'h06);
      fl('{8'hA1, 8'hFF, 8'hFF}, 15'h0000, 1, 8'h0D);
      eaOffset = 16'hFFFF;
      fl('{8'h8B, 8'h07}, 15'h0000, 1, 8'h0D);
      fl('{8'h8E, 8'h07}, 15'h0000, 1, 8'h0D);
      fl('{8'h8A, 8'h07}, 15'h0000, 0, 8'h00);
      eaOffset = 16'h0000;
      fl('{8'h90}, 15'h0001, 1, 8'h09);
      $display("real fault test done");
   endtask
   task automatic t_prot_faults();
      @(negedge clock);
      protMode = 1'b1;
      currentPrivilegeLevel = 2'h3;
      slow = 1'b1;
      fl('{8'h90}, 15'h2000, 1, 8'h0D);
      fl('{8'h8B, 8'h07}, 15'h0040, 1, 8'h0D);
      fl('{8'h8B, 8'h07}, 15'h0020, 1, 8'h0D);
      fl('{8'h8B, 8'h07}, 15'h0010, 1, 8'h0C);
      fl('{8'h90}, 15'h1010, 1, 8'h0C);
      fl('{8'h90}, 15'h1040, 1, 8'h0D);
      fl('{8'h90}, 15'h1001, 1, 8'h09);
      fl('{8'h90}, 15'h0404, 1, 8'h0B);
      fl('{8'h90}, 15'h0604, 1, 8'h0C);
      fl('{8'h8E, 8'hD0}, 15'h0004, 1, 8'h0C);
      fl('{8'h90}, 15'h0408, 1, 8'h0D);
      fl('{8'h90}, 15'h0102, 1, 8'h0D);
      fl('{8'h90}, 15'h0188, 1, 8'h0D);
      fl('{8'h90}, 15'h0108, 0, 8'h00);
      fl('{8'h90}, 15'h0808, 2, 8'h00);
      currentPrivilegeLevel = 2'h0;
      fl('{8'h90}, 15'h2000, 0, 8'h00);
      $display("protected fault test done");
   endtask
   task automatic t_lock();
      @(negedge clock);
      attrAutoLock = 1'b1;
      issue('{8'h90});
      chk(16'(lockSeen), 16'h0001);
      @(negedge clock);
      attrAutoLock = 1'b0;
      descAccess = 1'b1;
      issue('{8'h8E, 8'hD8});
      chk(16'(lockSeen), 16'h0001);
      chk(16'(opClocks), 16'h0011);
      chk(16'(opModrm), 16'h00D8);
      $display("lock test done");
   endtask
   initial begin
      clock = 1'b1;
      forever #50 clock = ~clock;
   end
   initial begin
      {rst, byteValid, protMode, attrAutoLock, descAccess} = 5'h10;
      {flagLoadValid, slow, byteData, currentPrivilegeLevel} = 12'h000;
      {at, eaOffset, flagLoadData} = 47'h0;
      repeat (6) @(posedge clock);
      @(negedge clock);
      rst = 1'b0;
      chk(flagWord, 16'h0000);
      chk(16'(byteReady), 16'h0001);
      t_moves();
      t_flags();
      t_real_faults();
      t_prot_faults();
      t_lock();
      give_verdict();
   end
endmodule
